// *** include/ewar_pkg.sv ***
// Package for the endpoint window address router.
// Assumes one core clock domain; all ports synchronous to it.
package ewar_pkg;
	localparam int unsigned ADDR_W        = 32;
	localparam int unsigned DATA_W        = 64;
	localparam int unsigned BE_W          = 8;
	localparam int unsigned LINK_ADDR_W   = 64;
	// Second window offsets
	localparam logic [31:0] CTRL_REG_LO   = 32'h0000_0000;
	localparam logic [31:0] CTRL_REG_HI   = 32'h0000_3fff;
	localparam logic [31:0] DMA_CTRL_LO   = 32'h0000_4000;
	localparam logic [31:0] DMA_CTRL_HI   = 32'h0000_403f;
	// Fabric map
	localparam logic [31:0] OUTB_BASE     = 32'h0000_0000;
	localparam logic [31:0] RAM_BASE      = 32'h0020_0000;
	localparam logic [31:0] RAM_SIZE      = 32'h0000_1000;
	localparam logic [31:0] WIN_LIMIT     = 32'h2000_0000;
	localparam int unsigned PAGE_BITS     = 20;
	localparam int unsigned PAGE_SEL_BIT  = 20;
	localparam int unsigned OUTB_CMP_LSB  = 21;
	localparam int unsigned XLAT_ENTRIES  = 2;
	localparam int unsigned XLAT_W        = LINK_ADDR_W - PAGE_BITS;
	localparam logic [XLAT_W-1:0] XLAT_RST = '0;
	localparam int unsigned IRQ_W         = 16;
	localparam int unsigned DMA_IRQ_BIT   = 0;
	localparam int unsigned FB_W          = 34;
	localparam int unsigned FB_PORT_W     = 17;
	localparam int unsigned LANES_WIDE    = 8;
	localparam logic [DATA_W-1:0] ERR_DATA = '0;

	typedef enum logic [1:0] {
		EWAR_T_NONE = 2'b00,
		EWAR_T_RAM  = 2'b01,
		EWAR_T_OUTB = 2'b10
	} ewar_tgt_e;

	function automatic logic ewar_in_range(input logic [31:0] a, input logic [31:0] lo,
		input logic [31:0] hi);
		return (a >= lo) && (a <= hi);
	endfunction
endpackage

// *** include/ewar_req_if.sv ***
// Request/answer bundle between the router and its fabric arbiter.
// Assumes single-cycle request with registered one-cycle answer.
`timescale 1ns/1ps
interface ewar_req_if;
	import ewar_pkg::*;
	logic              req;
	logic              wr;
	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] wdata;
	logic [BE_W-1:0]   be;
	logic              gnt;
	logic              rvalid;
	logic [DATA_W-1:0] rdata;
	logic              err;
	modport master (output req, wr, addr, wdata, be, input gnt, rvalid, rdata, err);
	modport slave  (input req, wr, addr, wdata, be, output gnt, rvalid, rdata, err);
endinterface

// *** hdl/ewar_fabric_dec.sv ***
// Fabric decoder: one request from a DMA master to RAM or outbound slave.
// Assumes the top sequences masters; answers come back via the top.
`timescale 1ns/1ps
module ewar_fabric_dec
	import ewar_pkg::*;
(
	// Request in
	input  wire logic [ADDR_W-1:0] addr,
	// Decode out
	output ewar_tgt_e              tgt,
	output logic [ADDR_W-1:0]      ram_off
);
	always_comb begin
		tgt     = EWAR_T_NONE;
		ram_off = addr - RAM_BASE;
		if (addr[ADDR_W-1:OUTB_CMP_LSB] == OUTB_BASE[ADDR_W-1:OUTB_CMP_LSB]) begin
			tgt = EWAR_T_OUTB;
		end else if (ewar_in_range(addr, RAM_BASE, RAM_BASE + RAM_SIZE - 32'h1)) begin
			tgt = EWAR_T_RAM;
		end
	end
endmodule

// *** hdl/ewar_xlat.sv ***
// Outbound translation: two page entries, bit 20 picks, low 20 bits pass.
// Assumes entries are written before outbound traffic is issued.
`timescale 1ns/1ps
module ewar_xlat
	import ewar_pkg::*;
(
	// Clock and reset
	input  wire logic                   clk,
	input  wire logic                   reset_n,
	// Table load
	input  wire logic                   ld_en,
	input  wire logic                   ld_idx,
	input  wire logic [XLAT_W-1:0]      ld_page,
	// Translate
	input  wire logic [ADDR_W-1:0]      fab_addr,
	output logic [LINK_ADDR_W-1:0]      link_addr
);
	typedef struct packed {
		logic [XLAT_ENTRIES-1:0][XLAT_W-1:0] page;
	} ewar_xlat_s;
	ewar_xlat_s st_r, st_nxt;

	always_comb begin
		st_nxt = st_r;
		if (ld_en) begin
			st_nxt.page[ld_idx] = ld_page;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			st_r <= '{page: {XLAT_RST, XLAT_RST}};
		end else begin
			st_r <= st_nxt;
		end
	end

	// Upper bits from the selected entry, page offset unchanged
	assign link_addr = {st_r.page[fab_addr[PAGE_SEL_BIT]],
		fab_addr[PAGE_BITS-1:0]};
endmodule

// *** hdl/ewar_router.sv ***
// Endpoint window address router: inbound window decode and DMA fabric.
// Assumes all ports on the endpoint core clock and core reset; the
// endpoint, RAM and DMA engine sit outside and answer in one cycle.
//
// Overview of operation
// - Inbound hits in the first window become RAM reads and writes.
// - Second-window offsets 0x0-0x3fff go to the endpoint control slave.
// - Second-window offsets 0x4000-0x403f go to the DMA control port.
// - Outbound accesses copy fabric address bits 19-0 into the link address.
// - Fabric address bit 20 picks one of the two translation entries.
// - The outbound slave is selected by fabric address bits 31:21.
// - The DMA interrupt drives bit 0 of the endpoint interrupt vector.
// - RAM and DMA engine run on the endpoint core clock and reset.
// - Both DMA masters reach the RAM and the outbound slave.
// - Only the eight-lane build carries the upper 17 feedback bits on a second port.
// - The translation table holds two entries loaded by the host.
`timescale 1ns/1ps
module ewar_router
	import ewar_pkg::*;
#(
	parameter int unsigned LANES = 8
)(
	// Core clock and reset
	input  wire logic                   clk,
	input  wire logic                   reset_n,
	// Inbound first window (ram_window_master)
	input  wire logic                   rwm_req,
	input  wire logic                   rwm_wr,
	input  wire logic [ADDR_W-1:0]      rwm_addr,
	input  wire logic [DATA_W-1:0]      rwm_wdata,
	input  wire logic [BE_W-1:0]        rwm_be,
	output logic                        rwm_rvalid,
	output logic [DATA_W-1:0]           rwm_rdata,
	// Inbound second window (control_window_master), offset addressed
	input  wire logic                   cwm_req,
	input  wire logic                   cwm_wr,
	input  wire logic [ADDR_W-1:0]      cwm_addr,
	input  wire logic [31:0]            cwm_wdata,
	output logic                        cwm_rvalid,
	output logic [31:0]                 cwm_rdata,
	output logic                        cwm_err,
	// DMA read master
	input  wire logic                   dmr_req,
	input  wire logic [ADDR_W-1:0]      dmr_addr,
	output logic                        dmr_gnt,
	output logic                        dmr_rvalid,
	output logic [DATA_W-1:0]           dmr_rdata,
	// DMA write master
	input  wire logic                   dmw_req,
	input  wire logic [ADDR_W-1:0]      dmw_addr,
	input  wire logic [DATA_W-1:0]      dmw_wdata,
	input  wire logic [BE_W-1:0]        dmw_be,
	output logic                        dmw_gnt,
	// RAM slave (ram_slave_port), one cycle read latency
	output logic                        ram_req,
	output logic                        ram_wr,
	output logic [ADDR_W-1:0]           ram_addr,
	output logic [DATA_W-1:0]           ram_wdata,
	output logic [BE_W-1:0]             ram_be,
	input  wire logic                   ram_rvalid,
	input  wire logic [DATA_W-1:0]      ram_rdata,
	// Endpoint outbound slave
	output logic                        outb_req,
	output logic                        outb_wr,
	output logic [LINK_ADDR_W-1:0]      outb_addr,
	output logic [DATA_W-1:0]           outb_wdata,
	output logic [BE_W-1:0]             outb_be,
	input  wire logic                   outb_rvalid,
	input  wire logic [DATA_W-1:0]      outb_rdata,
	// Endpoint control slave
	output logic                        ctl_req,
	output logic                        ctl_wr,
	output logic [ADDR_W-1:0]           ctl_addr,
	output logic [31:0]                 ctl_wdata,
	input  wire logic                   ctl_rvalid,
	input  wire logic [31:0]            ctl_rdata,
	// DMA control port
	output logic                        dcp_req,
	output logic                        dcp_wr,
	output logic [ADDR_W-1:0]           dcp_addr,
	output logic [31:0]                 dcp_wdata,
	input  wire logic                   dcp_rvalid,
	input  wire logic [31:0]            dcp_rdata,
	// Translation table load from host configuration
	input  wire logic                   xlat_ld_en,
	input  wire logic                   xlat_ld_idx,
	input  wire logic [XLAT_W-1:0]      xlat_ld_page,
	// Interrupts
	input  wire logic                   dma_irq,
	output logic [IRQ_W-1:0]            ep_irq,
	// Transceiver feedback
	input  wire logic [FB_W-1:0]        fb_bus,
	output logic [FB_PORT_W-1:0]        fb_port0,
	output logic [FB_PORT_W-1:0]        fb_port1
);
	typedef struct packed {
		logic                   rwm_rvalid;
		logic [DATA_W-1:0]      rwm_rdata;
		logic                   cwm_rvalid;
		logic [31:0]            cwm_rdata;
		logic                   cwm_err;
		logic                   dmr_gnt;
		logic                   dmr_rvalid;
		logic [DATA_W-1:0]      dmr_rdata;
		logic                   dmw_gnt;
		logic                   ram_req;
		logic                   ram_wr;
		logic [ADDR_W-1:0]      ram_addr;
		logic [DATA_W-1:0]      ram_wdata;
		logic [BE_W-1:0]        ram_be;
		logic                   outb_req;
		logic                   outb_wr;
		logic [LINK_ADDR_W-1:0] outb_addr;
		logic [DATA_W-1:0]      outb_wdata;
		logic [BE_W-1:0]        outb_be;
		logic                   ctl_req;
		logic                   ctl_wr;
		logic [ADDR_W-1:0]      ctl_addr;
		logic [31:0]            dwdata;
		logic                   dcp_req;
		logic [ADDR_W-1:0]      dcp_addr;
		logic                   ram_rd_own;   // 1: pending RAM read belongs to inbound
		logic                   ram_ans_own;  // Owner of the RAM answer now arriving
		logic                   dma_last;     // Round robin: last grant went to reader
		logic [IRQ_W-1:0]       ep_irq;
		logic [FB_PORT_W-1:0]   fb0;
		logic [FB_PORT_W-1:0]   fb1;
	} ewar_st_s;
	ewar_st_s st_r, st_nxt;

	ewar_req_if dma_bus ();
	ewar_tgt_e dtgt;
	logic [ADDR_W-1:0] dram_off;
	logic [LINK_ADDR_W-1:0] xl_addr;

	ewar_fabric_dec u_dec (
		.addr    (dma_bus.addr),
		.tgt     (dtgt),
		.ram_off (dram_off)
	);

	ewar_xlat u_xlat (
		.clk       (clk),
		.reset_n   (reset_n),
		.ld_en     (xlat_ld_en),
		.ld_idx    (xlat_ld_idx),
		.ld_page   (xlat_ld_page),
		.fab_addr  (dma_bus.addr),
		.link_addr (xl_addr)
	);

	// Pick one DMA master per cycle; inbound RAM traffic has priority
	logic pick_rd;
	logic ram_busy_in;
	always_comb begin
		ram_busy_in = rwm_req;
		pick_rd = dmr_req && (!dmw_req || !st_r.dma_last);
		dma_bus.req   = dmr_req || dmw_req;
		dma_bus.wr    = !pick_rd;
		dma_bus.addr  = pick_rd ? dmr_addr : dmw_addr;
		dma_bus.wdata = dmw_wdata;
		dma_bus.be    = pick_rd ? {BE_W{1'b1}} : dmw_be;
	end

	always_comb begin
		logic dma_go;
		dma_go = 1'b0;
		st_nxt = st_r;
		st_nxt.rwm_rvalid = 1'b0;
		st_nxt.cwm_rvalid = 1'b0;
		st_nxt.cwm_err    = 1'b0;
		st_nxt.dmr_gnt    = 1'b0;
		st_nxt.dmr_rvalid = 1'b0;
		st_nxt.dmw_gnt    = 1'b0;
		st_nxt.ram_req    = 1'b0;
		st_nxt.outb_req   = 1'b0;
		st_nxt.ctl_req    = 1'b0;
		st_nxt.dcp_req    = 1'b0;
		// Answer lags its request by two edges; a newer request must not steal it
		st_nxt.ram_ans_own = st_r.ram_rd_own;
		// Inbound first window: straight to RAM
		if (rwm_req) begin
			st_nxt.ram_req    = 1'b1;
			st_nxt.ram_wr     = rwm_wr;
			st_nxt.ram_addr   = rwm_addr;
			st_nxt.ram_wdata  = rwm_wdata;
			st_nxt.ram_be     = rwm_be;
			st_nxt.ram_rd_own = 1'b1;
		end
		// DMA masters: RAM only when inbound idle, outbound always free
		if (dma_bus.req) begin
			unique case (dtgt)
				EWAR_T_OUTB: begin
					dma_go = 1'b1;
					st_nxt.outb_req   = 1'b1;
					st_nxt.outb_wr    = dma_bus.wr;
					st_nxt.outb_addr  = xl_addr;
					st_nxt.outb_wdata = dma_bus.wdata;
					st_nxt.outb_be    = dma_bus.be;
				end
				EWAR_T_RAM: begin
					if (!ram_busy_in) begin
						dma_go = 1'b1;
						st_nxt.ram_req    = 1'b1;
						st_nxt.ram_wr     = dma_bus.wr;
						st_nxt.ram_addr   = dram_off;
						st_nxt.ram_wdata  = dma_bus.wdata;
						st_nxt.ram_be     = dma_bus.be;
						st_nxt.ram_rd_own = 1'b0;
					end
				end
				default: begin
					// Unmapped fabric address: grant and drop so the master never hangs
					dma_go = 1'b1;
				end
			endcase
			if (dma_go) begin
				st_nxt.dmr_gnt  = pick_rd;
				st_nxt.dmw_gnt  = !pick_rd;
				st_nxt.dma_last = pick_rd;
				if (pick_rd && dtgt == EWAR_T_NONE) begin
					st_nxt.dmr_rvalid = 1'b1;
					st_nxt.dmr_rdata  = ERR_DATA;
				end
			end
		end
		// Read answers
		if (ram_rvalid) begin
			if (st_r.ram_ans_own) begin
				st_nxt.rwm_rvalid = 1'b1;
				st_nxt.rwm_rdata  = ram_rdata;
			end else begin
				st_nxt.dmr_rvalid = 1'b1;
				st_nxt.dmr_rdata  = ram_rdata;
			end
		end
		if (outb_rvalid) begin
			st_nxt.dmr_rvalid = 1'b1;
			st_nxt.dmr_rdata  = outb_rdata;
		end
		// Second window decode on the offset
		if (cwm_req) begin
			st_nxt.ctl_wr = cwm_wr;
			st_nxt.dwdata = cwm_wdata;
			if (ewar_in_range(cwm_addr, CTRL_REG_LO, CTRL_REG_HI)) begin
				st_nxt.ctl_req  = 1'b1;
				st_nxt.ctl_addr = cwm_addr - CTRL_REG_LO;
			end else if (ewar_in_range(cwm_addr, DMA_CTRL_LO, DMA_CTRL_HI)) begin
				st_nxt.dcp_req  = 1'b1;
				st_nxt.dcp_addr = cwm_addr - DMA_CTRL_LO;
			end else begin
				// No slave touched; reads see zero
				st_nxt.cwm_rvalid = !cwm_wr;
				st_nxt.cwm_rdata  = '0;
				st_nxt.cwm_err    = 1'b1;
			end
		end
		if (ctl_rvalid) begin
			st_nxt.cwm_rvalid = 1'b1;
			st_nxt.cwm_rdata  = ctl_rdata;
		end else if (dcp_rvalid) begin
			st_nxt.cwm_rvalid = 1'b1;
			st_nxt.cwm_rdata  = dcp_rdata;
		end
		st_nxt.ep_irq = '0;
		st_nxt.ep_irq[DMA_IRQ_BIT] = dma_irq;
		st_nxt.fb0 = fb_bus[FB_PORT_W-1:0];
		st_nxt.fb1 = (LANES == LANES_WIDE) ? fb_bus[FB_W-1:FB_PORT_W] : '0;
	end

	// Same clock and reset as the RAM and DMA engine share
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign dma_bus.gnt    = st_r.dmr_gnt | st_r.dmw_gnt;
	assign dma_bus.rvalid = st_r.dmr_rvalid;
	assign dma_bus.rdata  = st_r.dmr_rdata;
	assign dma_bus.err    = 1'b0;

	assign rwm_rvalid = st_r.rwm_rvalid;
	assign rwm_rdata  = st_r.rwm_rdata;
	assign cwm_rvalid = st_r.cwm_rvalid;
	assign cwm_rdata  = st_r.cwm_rdata;
	assign cwm_err    = st_r.cwm_err;
	assign dmr_gnt    = st_r.dmr_gnt;
	assign dmr_rvalid = st_r.dmr_rvalid;
	assign dmr_rdata  = st_r.dmr_rdata;
	assign dmw_gnt    = st_r.dmw_gnt;
	assign ram_req    = st_r.ram_req;
	assign ram_wr     = st_r.ram_wr;
	assign ram_addr   = st_r.ram_addr;
	assign ram_wdata  = st_r.ram_wdata;
	assign ram_be     = st_r.ram_be;
	assign outb_req   = st_r.outb_req;
	assign outb_wr    = st_r.outb_wr;
	assign outb_addr  = st_r.outb_addr;
	assign outb_wdata = st_r.outb_wdata;
	assign outb_be    = st_r.outb_be;
	assign ctl_req    = st_r.ctl_req;
	assign ctl_wr     = st_r.ctl_wr;
	assign ctl_addr   = st_r.ctl_addr;
	assign ctl_wdata  = st_r.dwdata;
	assign dcp_req    = st_r.dcp_req;
	assign dcp_wr     = st_r.ctl_wr;
	assign dcp_addr   = st_r.dcp_addr;
	assign dcp_wdata  = st_r.dwdata;
	assign ep_irq     = st_r.ep_irq;
	assign fb_port0   = st_r.fb0;
	assign fb_port1   = st_r.fb1;
endmodule

// *** bench/ewar_router_assertions.sv ***
// Checker for the window router: routing, translation, interrupt, feedback.
// Assumes it is bound onto the router top and sees its ports only.
`timescale 1ns/1ps
module ewar_router_assertions
	import ewar_pkg::*;
#(
	parameter int unsigned LANES = 8
)(
	// Clock and reset
	input wire logic clk, reset_n,
	// Inbound windows
	input wire logic rwm_req, rwm_wr, cwm_req, cwm_wr, cwm_rvalid, cwm_err,
	input wire logic [ADDR_W-1:0] rwm_addr, cwm_addr,
	input wire logic [31:0] cwm_rdata,
	// Fabric and slaves
	input wire logic dmw_gnt, ram_req, ram_wr, outb_req, outb_wr, ctl_req, dcp_req,
	input wire logic [ADDR_W-1:0] dmw_addr, ram_addr, ctl_addr, dcp_addr,
	input wire logic [LINK_ADDR_W-1:0] outb_addr,
	// Table load, interrupt, feedback
	input wire logic xlat_ld_en, xlat_ld_idx, dma_irq,
	input wire logic [XLAT_W-1:0] xlat_ld_page,
	input wire logic [IRQ_W-1:0] ep_irq,
	input wire logic [FB_W-1:0] fb_bus,
	input wire logic [FB_PORT_W-1:0] fb_port1
);
	logic [XLAT_W-1:0]    ent_r [2];
	logic [ADDR_W-1:0]    wa_r;
	logic [FB_PORT_W-1:0] fb_r;

	// Shadow table; write address kept so the grant cycle can see it
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			ent_r <= '{XLAT_RST, XLAT_RST};
			wa_r <= '0;
			fb_r <= '0;
		end else begin
			if (xlat_ld_en)
				ent_r[xlat_ld_idx] <= xlat_ld_page;
			wa_r <= dmw_addr;
			fb_r <= LANES == LANES_WIDE ? fb_bus[FB_W-1:FB_PORT_W] : '0;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	sequence s_ctl_hit;
		cwm_req && cwm_addr <= CTRL_REG_HI;
	endsequence
	sequence s_dcp_hit;
		cwm_req && cwm_addr >= DMA_CTRL_LO && cwm_addr <= DMA_CTRL_HI;
	endsequence
	sequence s_miss;
		cwm_req && cwm_addr > DMA_CTRL_HI;
	endsequence

	ctl_route_a: assert property (
		s_ctl_hit |=> ctl_req && !dcp_req && ctl_addr == $past(cwm_addr))
		else $error("control offset not routed to control slave");
	dcp_route_a: assert property (
		s_dcp_hit |=> dcp_req && !ctl_req && dcp_addr == $past(cwm_addr) - DMA_CTRL_LO)
		else $error("dma control offset misrouted");
	miss_quiet_a: assert property (
		s_miss |=> cwm_err && !ctl_req && !dcp_req)
		else $error("unmatched offset reached a slave");
	miss_read_a: assert property (
		s_miss ##0 !cwm_wr |=> cwm_rvalid && cwm_rdata == '0)
		else $error("unmatched read did not return zero");
	ram_forward_a: assert property (
		rwm_req |=> ram_req && ram_wr == $past(rwm_wr) && ram_addr == $past(rwm_addr))
		else $error("first window request not sent to ram");
	low_bits_a: assert property (
		dmw_gnt && outb_req |-> outb_wr && outb_addr[19:0] == wa_r[19:0])
		else $error("outbound low address bits altered");
	page_pick_a: assert property (
		dmw_gnt && outb_req |-> outb_addr[LINK_ADDR_W-1:PAGE_BITS] == ent_r[wa_r[20]])
		else $error("wrong translation entry used");
	outb_select_a: assert property (
		dmw_gnt |-> outb_req == (wa_r[31:21] == OUTB_BASE[31:21]))
		else $error("outbound slave select wrong");
	irq_bit_a: assert property (
		$rose(dma_irq) |=> ep_irq == IRQ_W'(1))
		else $error("dma interrupt not on bit zero");
	fb_upper_a: assert property (
		fb_port1 == fb_r)
		else $error("upper feedback port wrong");
endmodule

// *** bench/ewar_partner.sv ***
// Far-side model: on-chip RAM, outbound slave, control slave, DMA control port.
// Assumes one-cycle read answers on the router core clock and reset.
`timescale 1ns/1ps
module ewar_partner
	import ewar_pkg::*;
#(
	parameter logic [63:0] K = 64'h0
)(
	// Core clock and reset
	input wire logic clk, reset_n,
	// RAM slave
	input wire logic ram_req, ram_wr,
	input wire logic [ADDR_W-1:0] ram_addr,
	input wire logic [DATA_W-1:0] ram_wdata,
	input wire logic [BE_W-1:0] ram_be,
	output logic ram_rvalid,
	output logic [DATA_W-1:0] ram_rdata,
	// Outbound slave
	input wire logic outb_req, outb_wr,
	input wire logic [LINK_ADDR_W-1:0] outb_addr,
	output logic outb_rvalid,
	output logic [DATA_W-1:0] outb_rdata,
	// Control slave and DMA control port
	input wire logic ctl_req, ctl_wr, dcp_req, dcp_wr,
	input wire logic [ADDR_W-1:0] ctl_addr, dcp_addr,
	output logic ctl_rvalid, dcp_rvalid,
	output logic [31:0] ctl_rdata, dcp_rdata
);
	logic [DATA_W-1:0] mem [512];

	// Same core clock and reset as the router
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			foreach (mem[i])
				mem[i] <= '0;
			{ram_rvalid, outb_rvalid, ctl_rvalid, dcp_rvalid} <= '0;
			{ram_rdata, outb_rdata, ctl_rdata, dcp_rdata} <= '0;
		end else begin
			// Idle data flips each cycle so a stale word never matches
			ram_rvalid <= ram_req && !ram_wr;
			ram_rdata <= ram_req && !ram_wr ? mem[ram_addr[11:3]] : ~ram_rdata;
			if (ram_req && ram_wr)
				for (int b = 0; b < 8; b++)
					if (ram_be[b])
						mem[ram_addr[11:3]][8*b+:8] <= ram_wdata[8*b+:8];
			outb_rvalid <= outb_req && !outb_wr;
			outb_rdata <= outb_req && !outb_wr ? outb_addr ^ K : ~outb_rdata;
			ctl_rvalid <= ctl_req && !ctl_wr;
			ctl_rdata <= ctl_req && !ctl_wr ? ctl_addr ^ K[31:0] : ~ctl_rdata;
			dcp_rvalid <= dcp_req && !dcp_wr;
			dcp_rdata <= dcp_req && !dcp_wr ? dcp_addr ^ K[63:32] : ~dcp_rdata;
		end
	end
endmodule

// *** bench/test_ewar_router.sv ***
// Self-checking bench for the window router against a behavioural model.
// Assumes the far-side model ewar_partner and the checker bound below.
`timescale 1ns/1ps
module test_ewar_router;
	import ewar_pkg::*;
	localparam int unsigned LANES = 8;
	localparam logic [63:0] K = 64'h5a3c_96e1_0f78_c3a5;
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	logic rwm_req, rwm_wr, cwm_req, cwm_wr, dmr_req, dmw_req, dma_irq;
	logic xlat_ld_en, xlat_ld_idx, ob_req;
	logic [ADDR_W-1:0] rwm_addr, cwm_addr, dmr_addr, dmw_addr, ram_addr, ctl_addr, dcp_addr;
	logic [DATA_W-1:0] rwm_wdata, dmw_wdata, rwm_rdata, dmr_rdata, ram_wdata, ram_rdata;
	logic [DATA_W-1:0] outb_wdata, outb_rdata;
	logic [BE_W-1:0] rwm_be, dmw_be, ram_be, outb_be;
	logic [31:0] cwm_wdata, cwm_rdata, ctl_wdata, ctl_rdata, dcp_wdata, dcp_rdata;
	logic rwm_rvalid, cwm_rvalid, cwm_err, dmr_gnt, dmr_rvalid, dmw_gnt, ram_req, ram_wr;
	logic ram_rvalid, outb_req, outb_wr, outb_rvalid, ctl_req, ctl_wr, ctl_rvalid;
	logic dcp_req, dcp_wr, dcp_rvalid;
	logic [LINK_ADDR_W-1:0] outb_addr, ob_addr;
	logic [XLAT_W-1:0] xlat_ld_page, page_m [2];
	logic [IRQ_W-1:0] ep_irq;
	logic [FB_W-1:0] fb_bus;
	logic [FB_PORT_W-1:0] fb_port0, fb_port1;
	logic [63:0] mem_m [int];
	logic [31:0] offs [8] = '{32'h0, 32'h1ff8, 32'h3fff, 32'h4000, 32'h4024, 32'h403f,
		32'h4040, 32'h0100_0000};
	int err_count = 0;
	int comparisons = 0;
	int seed = 32'h4ac5;

	ewar_router #(.LANES(LANES)) i_dut (.*);
	ewar_partner #(.K(K)) i_far (.*);

	always #12.5 clk = ~clk;

	task automatic tick;
		@(posedge clk);
		#2;
	endtask
	task automatic chk(string n, logic [63:0] e, logic [63:0] s);
		comparisons++;
		if (s !== e) begin
			err_count++;
			$display("ERROR %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic await(ref logic s);
		for (int i = 0; i < 8 && s !== 1'b1; i++)
			tick;
		chk("handshake", 1, s);
	endtask
	function automatic logic [63:0] rd_m(logic [31:0] a);
		return mem_m.exists(a[11:3]) ? mem_m[a[11:3]] : '0;
	endfunction
	task automatic ram_acc(bit wr, logic [31:0] a, logic [63:0] d, logic [7:0] be);
		logic [63:0] o;
		rwm_req = 1'b1;
		rwm_wr = wr;
		rwm_addr = a;
		rwm_wdata = d;
		rwm_be = be;
		tick;
		rwm_req = 1'b0;
		o = rd_m(a);
		for (int b = 0; b < 8; b++)
			if (wr && be[b])
				o[8*b+:8] = d[8*b+:8];
		mem_m[a[11:3]] = o;
		if (!wr) begin
			await(rwm_rvalid);
			chk("rwm_rdata", o, rwm_rdata);
		end
		tick;
	endtask
	task automatic win2(bit wr, logic [31:0] a);
		logic [31:0] e;
		e = a <= CTRL_REG_HI ? a ^ K[31:0] : a <= DMA_CTRL_HI ? (a - DMA_CTRL_LO) ^ K[63:32] : '0;
		cwm_req = 1'b1;
		cwm_wr = wr;
		cwm_addr = a;
		cwm_wdata = $random(seed);
		tick;
		cwm_req = 1'b0;
		if (wr && a <= DMA_CTRL_HI) begin
			chk("slave_wr", 1, a <= CTRL_REG_HI ? ctl_wr : dcp_wr);
			chk("slave_wdata", cwm_wdata, a <= CTRL_REG_HI ? ctl_wdata : dcp_wdata);
		end
		if (!wr) begin
			await(cwm_rvalid);
			chk("cwm_rdata", e, cwm_rdata);
			chk("cwm_err", a > DMA_CTRL_HI, cwm_err);
		end
		tick;
	endtask
	// Request held until its grant, then dropped before the next edge
	task automatic dma(bit wr, logic [31:0] a, logic [63:0] d);
		dmw_req = wr;
		dmr_req = !wr;
		dmw_addr = a;
		dmr_addr = a;
		dmw_wdata = d;
		dmw_be = 8'hff;
		tick;
		for (int i = 0; i < 8 && (wr ? dmw_gnt : dmr_gnt) !== 1'b1; i++)
			tick;
		chk("dma_gnt", 1, wr ? dmw_gnt : dmr_gnt);
		ob_req = outb_req;
		ob_addr = outb_addr;
		if (wr && outb_req === 1'b1) begin
			chk("outb_wdata", d, outb_wdata);
			chk("outb_be", 8'hff, outb_be);
		end
		dmw_req = 1'b0;
		dmr_req = 1'b0;
		tick;
	endtask
	task automatic tally_and_finish;
		$display("mismatches %0d comparisons %0d", err_count, comparisons);
		if (err_count == 0 && comparisons > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	initial begin
		repeat (4000) @(posedge clk);
		err_count++;
		tally_and_finish;
	end

	initial begin
		logic [31:0] a;
		logic [63:0] d;
		{rwm_req, rwm_wr, cwm_req, cwm_wr, dmr_req, dmw_req, dma_irq} = '0;
		{xlat_ld_en, xlat_ld_idx, xlat_ld_page, fb_bus, cwm_wdata} = '0;
		{rwm_addr, cwm_addr, dmr_addr, dmw_addr, rwm_be, dmw_be} = '0;
		{rwm_wdata, dmw_wdata} = '0;
		repeat (16) @(posedge clk);
		#2;
		reset_n = 1'b1;
		chk("ep_irq", 0, ep_irq);
		for (int i = 0; i < 8; i++) begin
			a = RAM_BASE + ($random(seed) & 32'h0000_0ff8);
			ram_acc(1, a, {$random(seed), $random(seed)}, $random(seed));
			ram_acc(0, a, '0, 8'hff);
		end
		foreach (offs[i]) begin
			win2(1, offs[i]);
			win2(0, offs[i]);
		end
		for (int i = 0; i < 2; i++) begin
			page_m[i] = XLAT_W'({$random(seed), $random(seed)});
			xlat_ld_en = 1'b1;
			xlat_ld_idx = i[0];
			xlat_ld_page = page_m[i];
			tick;
		end
		xlat_ld_en = 1'b0;
		tick;
		for (int i = 0; i < 4; i++) begin
			a = {11'h0, i[0], 20'($random(seed))};
			dma(i[1], a, {$random(seed), $random(seed)});
			chk("outb_req", 1, ob_req);
			chk("outb_addr", {page_m[i[0]], a[19:0]}, ob_addr);
			if (!i[1]) begin
				await(dmr_rvalid);
				chk("dmr_rdata", {page_m[i[0]], a[19:0]} ^ K, dmr_rdata);
			end
		end
		a = RAM_BASE + 32'h0000_0ab8;
		d = {$random(seed), $random(seed)};
		dma(1, a, d);
		chk("outb_req", 0, ob_req);
		mem_m[a[11:3]] = d;
		ram_acc(0, a, '0, 8'hff);
		dma(0, a, '0);
		await(dmr_rvalid);
		chk("dmr_rdata", d, dmr_rdata);
		// Inbound read and both DMA masters on the RAM at once: inbound first
		rwm_req = 1'b1;
		rwm_wr = 1'b0;
		rwm_addr = RAM_BASE + 32'h0000_0010;
		dmr_req = 1'b1;
		dmr_addr = a;
		dmw_req = 1'b1;
		dmw_addr = a + 32'h0000_0008;
		dmw_wdata = ~d;
		dmw_be = 8'hff;
		tick;
		rwm_req = 1'b0;
		chk("dma_gnt", 0, dmr_gnt | dmw_gnt);
		for (int i = 0; i < 2; i++) begin
			tick;
			chk("dma_gnt", 1, dmr_gnt ^ dmw_gnt);
			if (dmr_gnt === 1'b1)
				dmr_req = 1'b0;
			if (dmw_gnt === 1'b1)
				dmw_req = 1'b0;
		end
		chk("rwm_rvalid", 1, rwm_rvalid);
		chk("rwm_rdata", rd_m(RAM_BASE + 32'h0000_0010), rwm_rdata);
		mem_m[a[11:3] + 9'h1] = ~d;
		await(dmr_rvalid);
		chk("dmr_rdata", d, dmr_rdata);
		ram_acc(0, a + 32'h0000_0008, '0, 8'hff);
		dma(1, 32'h1000_0000, '0);
		chk("outb_req", 0, ob_req);
		dma_irq = 1'b1;
		tick;
		tick;
		chk("ep_irq", 1, ep_irq);
		dma_irq = 1'b0;
		fb_bus = FB_W'({$random(seed), $random(seed)});
		tick;
		tick;
		chk("ep_irq", 0, ep_irq);
		chk("fb_port0", fb_bus[16:0], fb_port0);
		chk("fb_port1", fb_bus[33:17], fb_port1);
		tally_and_finish;
	end
endmodule

bind ewar_router ewar_router_assertions #(.LANES(LANES)) i_chk (.*);
